// file: design/level_detector_pkg.sv
// Purpose: constants for the input level detector and host test word
// Assumes: global write locations decoded in the detector from the host port wr_addr
// Notes: config fields sit in a 32-bit word, upper bits read as zero
package level_detector_pkg;
    localparam logic [15:0] addr_config = 16'hF805;
    localparam logic [15:0] addr_start = 16'hF806;
    localparam logic [15:0] addr_test_word = 16'hF807;
    localparam logic [15:0] addr_test_strobe = 16'hF808;
    localparam int bit_rectify = 21;
    localparam int bit_free_run = 20;
    localparam int leak_hi = 19;
    localparam int leak_lo = 18;
    localparam int mode_hi = 17;
    localparam int mode_lo = 16;
    localparam int cfg_width = 22;
    localparam logic [31:0] config_reset = 32'h0000_0000;
    localparam logic [15:0] test_word_reset = 16'h0000;
    localparam logic [1:0] mode_leaky = 2'h0;
    localparam logic [1:0] mode_peak = 2'h1;
    localparam logic [1:0] mode_integrate = 2'h2;
    localparam logic [1:0] leak_one = 2'h0;
    localparam logic [1:0] leak_8 = 2'h1;
    localparam logic [1:0] leak_12 = 2'h2;
    localparam logic [1:0] leak_16 = 2'h3;
    localparam int shift_8 = 8;
    localparam int shift_12 = 12;
    localparam int shift_16 = 16;
    localparam int acc_width = 40;
    localparam int frac_width = 16;
    localparam logic [15:0] interval_reset = 16'h0000;
    localparam int interval_hi = 15;
    localparam int interval_lo = 0;
    localparam int word_hi = 15;
    localparam int sample_sign = 15;
    localparam int result_lo = 8;
endpackage : level_detector_pkg

// file: design/input_level_detector.sv
// Purpose: input level detector with host-driven test input word
// Assumes: write strobe and address come from logic on ref_clk
// Notes: sample_in and sample_enable_strobe are on ref_clk as well
`timescale 1ns/1ps
module input_level_detector (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [15:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [15:0] sample_in,
    input wire logic sample_enable_strobe,
    input wire logic detector_use_test_word,
    input wire logic channel_enable_bit,
    input wire logic channel_strobe_select,
    input wire logic interpolated_mode,
    output logic [31:0] config_read,
    output logic [15:0] test_word_read,
    output logic [15:0] test_word,
    output logic channel_sample_enable,
    output logic [31:0] level_result,
    output logic interval_done
);
    logic [31:0] cfg;
    logic [31:0] next_cfg;
    logic [15:0] tword;
    logic [15:0] next_tword;
    logic tstrobe;
    logic next_tstrobe;
    logic [39:0] acc;
    logic [39:0] next_acc;
    logic [16:0] count;
    logic [16:0] next_count;
    logic running;
    logic next_running;
    logic done;
    logic next_done;
    logic chan_en;
    logic next_chan_en;

    logic [15:0] src;
    logic src_en;
    logic [15:0] rect;
    logic [39:0] x_ext;
    logic [39:0] delta;
    logic update;

    logic start_wr;
    logic test_pulse;
    logic wr_config;
    logic wr_test_word;
    logic rectify_on;
    logic free_run_on;
    logic [1:0] leak_sel;
    logic [1:0] mode_sel;
    logic [15:0] interval_load;
    logic signed [39:0] diff;

    // register decode and config fields
    always_comb begin
        wr_config = wr_en && (wr_addr == level_detector_pkg::addr_config);
        wr_test_word = wr_en
            && (wr_addr == level_detector_pkg::addr_test_word);
        start_wr = wr_en && (wr_addr == level_detector_pkg::addr_start);
        test_pulse = wr_en
            && (wr_addr == level_detector_pkg::addr_test_strobe);
        rectify_on = cfg[level_detector_pkg::bit_rectify];
        free_run_on = cfg[level_detector_pkg::bit_free_run];
        leak_sel = cfg[level_detector_pkg::leak_hi:
            level_detector_pkg::leak_lo];
        mode_sel = cfg[level_detector_pkg::mode_hi:
            level_detector_pkg::mode_lo];
        interval_load = cfg[level_detector_pkg::interval_hi:
            level_detector_pkg::interval_lo];
    end

    // write-side register next values
    always_comb begin
        next_cfg = cfg;
        if (wr_config) begin
            next_cfg = {10'h000,
                wr_data[level_detector_pkg::cfg_width-1:0]};
        end
        next_tword = tword;
        if (wr_test_word) begin
            next_tword = wr_data[level_detector_pkg::word_hi:0];
        end
        next_tstrobe = test_pulse;
        // enable source chosen per channel
        next_chan_en = channel_strobe_select ? tstrobe
                                             : channel_enable_bit;
    end

    // config, test word and strobe registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfg <= level_detector_pkg::config_reset;
            tword <= level_detector_pkg::test_word_reset;
            tstrobe <= 1'b0;
            chan_en <= 1'b0;
        end else begin
            cfg <= next_cfg;
            tword <= next_tword;
            tstrobe <= next_tstrobe;
            chan_en <= next_chan_en;
        end
    end

    // detector datapath and interval control
    always_comb begin
        // sample source, rectifier and interpolation zeroing
        src = detector_use_test_word ? tword : sample_in;
        src_en = detector_use_test_word ? chan_en : sample_enable_strobe;
        rect = src;
        if (rectify_on && src[level_detector_pkg::sample_sign]) begin
            rect = ~src;
        end
        if (interpolated_mode && src_en) begin
            rect = 16'h0000;
        end
        update = interpolated_mode ? 1'b1 : src_en;
        x_ext = {{8{rect[level_detector_pkg::sample_sign]}}, rect, 16'h0000};
        // signed difference keeps the leak step sign-correct
        diff = $signed(x_ext - acc);
        delta = diff;
        unique case (leak_sel)
            level_detector_pkg::leak_one: delta = diff;
            level_detector_pkg::leak_8: begin
                delta = diff >>> level_detector_pkg::shift_8;
            end
            level_detector_pkg::leak_12: begin
                delta = diff >>> level_detector_pkg::shift_12;
            end
            level_detector_pkg::leak_16: begin
                delta = diff >>> level_detector_pkg::shift_16;
            end
        endcase

        next_acc = acc;
        next_count = count;
        next_running = running;
        next_done = done;
        if (start_wr) begin
            next_acc = 40'h00_0000_0000;
            next_count = {1'b0, interval_load} + 17'h0_0001;
            next_running = 1'b1;
            next_done = 1'b0;
        end else if (update && (running || free_run_on)) begin
            unique case (mode_sel)
                level_detector_pkg::mode_leaky: begin
                    next_acc = acc + delta;
                end
                level_detector_pkg::mode_integrate: begin
                    next_acc = acc + x_ext;
                end
                default: begin
                    // peak and reserved codes leave the value frozen
                    next_acc = acc;
                end
            endcase
            if (running) begin
                if (count == 17'h0_0000) begin
                    next_running = 1'b0;
                    next_done = 1'b1;
                end else begin
                    next_count = count - 17'h0_0001;
                end
            end
        end
    end

    // accumulator, interval counter and status
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            acc <= 40'h00_0000_0000;
            count <= 17'h0_0000;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            acc <= next_acc;
            count <= next_count;
            running <= next_running;
            done <= next_done;
        end
    end

    // outputs register the next values
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            config_read <= 32'h0000_0000;
            test_word_read <= 16'h0000;
            test_word <= 16'h0000;
            channel_sample_enable <= 1'b0;
            level_result <= 32'h0000_0000;
            interval_done <= 1'b0;
        end else begin
            config_read <= next_cfg;
            test_word_read <= next_tword;
            test_word <= next_tword;
            channel_sample_enable <= next_chan_en;
            level_result <= next_acc[39:level_detector_pkg::result_lo];
            interval_done <= next_done;
        end
    end
endmodule : input_level_detector

// file: dv/input_level_detector_asserts.sv
// Purpose: port checker for input_level_detector
// Assumes: all inputs change on rising ref_clk
// Notes: bound to the design below
`timescale 1ns/1ps
module input_level_detector_asserts (
    input wire logic ref_clk, reset, wr_en,
    input wire logic [15:0] wr_addr, sample_in, test_word_read, test_word,
    input wire logic [31:0] wr_data, config_read, level_result,
    input wire logic sample_enable_strobe, detector_use_test_word,
    input wire logic channel_enable_bit, channel_strobe_select,
    input wire logic interpolated_mode, channel_sample_enable, interval_done
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic go, wcfg, wtw, wstb;
    assign go = wr_en && wr_addr == level_detector_pkg::addr_start;
    assign wcfg = wr_en && wr_addr == level_detector_pkg::addr_config;
    assign wtw = wr_en && wr_addr == level_detector_pkg::addr_test_word;
    assign wstb = wr_en && wr_addr == level_detector_pkg::addr_test_strobe;
    AST_START_CLR: assert property (go |=> level_result == 32'h0
        && !interval_done) else $error("start did not clear");
    AST_CFG_RB: assert property (wcfg |=>
        config_read == {10'h000, $past(wr_data[21:0])})
        else $error("config readback wrong");
    AST_TW: assert property (wtw |=> test_word == $past(wr_data[15:0])
        && test_word_read == test_word) else $error("test word wrong");
    AST_STROBE: assert property (wstb && channel_strobe_select ##1
        channel_strobe_select |=> channel_sample_enable)
        else $error("no strobe enable");
    AST_DONE_HOLD: assert property (interval_done && !go |=>
        interval_done) else $error("done dropped");
    AST_HOLD_AFTER: assert property (interval_done && !config_read[20]
        && !wr_en |=> $stable(level_result)) else $error("acc moved");
    AST_RSV_MODE: assert property ((config_read[16] && !wr_en)[*2]
        |=> $stable(level_result)) else $error("mode moved acc");
    AST_GATED_IDLE: assert property ((!interpolated_mode && !wr_en
        && !detector_use_test_word && !sample_enable_strobe)[*2]
        |=> $stable(level_result)) else $error("idle update");
endmodule : input_level_detector_asserts
bind input_level_detector input_level_detector_asserts u_chk (.ref_clk,
    .reset, .wr_en, .wr_addr, .sample_in, .test_word_read, .test_word,
    .wr_data, .config_read, .level_result, .sample_enable_strobe,
    .detector_use_test_word, .channel_enable_bit, .channel_strobe_select,
    .interpolated_mode, .channel_sample_enable, .interval_done);

// file: dv/input_level_detector_tb_top.sv
// Purpose: directed bench for input_level_detector
// Assumes: writes are one-cycle wr_en pulses
// Notes: stimulus on rising ref_clk
`timescale 1ns/1ps
module input_level_detector_tb_top;
    logic ref_clk, reset, wr_en, sample_enable_strobe, detector_use_test_word;
    logic channel_enable_bit, channel_strobe_select, interpolated_mode;
    logic channel_sample_enable, interval_done;
    logic [15:0] wr_addr, sample_in, test_word_read, test_word;
    logic [31:0] wr_data, config_read, level_result;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [31:0] tc [6] = '{32'h0010_0000, 32'h0014_0000, 32'h0018_0000,
        32'h001C_0000, 32'h0030_0000, 32'h0010_0000};
    logic [31:0] te [6] = '{32'h0010_0000, 32'h0000_1000, 32'h0000_0100,
        32'h0000_0010, 32'h0000_0400, 32'hFFFF_FB00};
    input_level_detector DUT (.ref_clk, .reset, .wr_en, .wr_addr, .wr_data,
        .sample_in, .sample_enable_strobe, .detector_use_test_word,
        .channel_enable_bit, .channel_strobe_select, .interpolated_mode,
        .config_read, .test_word_read, .test_word, .channel_sample_enable,
        .level_result, .interval_done);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        cyc(1);
    endtask : wr
    task automatic feed(input logic [15:0] x, input int n);
        @(posedge ref_clk);
        sample_in <= x;
        sample_enable_strobe <= 1'b1;
        repeat (n) @(posedge ref_clk);
        sample_enable_strobe <= 1'b0;
        cyc(2);
    endtask : feed
    task automatic wdone;
        for (int i = 0; i < 40 && interval_done !== 1'b1; i++) cyc(1);
        if (interval_done !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : wdone
    initial begin
        reset = 1'b1;
        {wr_en, sample_enable_strobe, detector_use_test_word} = 3'h0;
        {channel_enable_bit, channel_strobe_select, interpolated_mode} = 3'h0;
        wr_addr = 16'h0000;
        wr_data = 32'h0000_0000;
        sample_in = 16'h0000;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        cyc(1);
        for (int i = 0; i < 6; i++) begin
            wr(16'hF805, tc[i]);
            chk(config_read, tc[i]);
            wr(16'hF806, 32'h0);
            feed(16'h1000 ^ (i > 3 ? 16'hEFFB : 16'h0), 1);
            chk(level_result, te[i]);
        end
        wr(16'hF805, 32'h0014_0000);
        wr(16'hF806, 32'h0000_0000);
        feed(16'h1000, 1);
        feed(16'hF000, 1);
        chk(level_result, 32'hFFFF_FFF0);
        wr(16'hF805, 32'h0004_0000);
        feed(16'h1000, 3);
        chk(level_result, 32'hFFFF_FFF0);
        $display("test leak end");
        wr(16'hF805, 32'h0002_0001);
        wr(16'hF806, 32'h0000_0000);
        chk(level_result, 32'h0);
        feed(16'h0010, 5);
        chk(level_result, 32'h0000_3000);
        chk({31'h0, interval_done}, 32'h1);
        $display("test interval end");
        interpolated_mode <= 1'b1;
        wr(16'hF805, 32'h0002_0002);
        wr(16'hF806, 32'h0000_0000);
        feed(16'h0010, 1);
        wdone();
        chk(level_result, 32'h0000_3000);
        interpolated_mode <= 1'b0;
        $display("test interpolated end");
        wr(16'hF807, 32'h0000_0123);
        chk({16'h0, test_word}, 32'h0000_0123);
        chk({16'h0, test_word_read}, 32'h0000_0123);
        detector_use_test_word <= 1'b1;
        channel_strobe_select <= 1'b1;
        wr(16'hF805, 32'h0002_0000);
        wr(16'hF806, 32'h0000_0000);
        wr(16'hF808, 32'h0000_0000);
        wr(16'hF808, 32'h0000_0000);
        wdone();
        chk(level_result, 32'h0002_4600);
        channel_strobe_select <= 1'b0;
        channel_enable_bit <= 1'b1;
        cyc(3);
        chk({31'h0, channel_sample_enable}, 32'h1);
        channel_enable_bit <= 1'b0;
        detector_use_test_word <= 1'b0;
        $display("test word end");
        wr(16'hF805, 32'h0013_0000);
        wr(16'hF809, 32'h0000_0000);
        chk(config_read, 32'h0013_0000);
        feed(16'h0010, 2);
        chk(level_result, 32'h0002_4600);
        $display("test reserved end");
        give_verdict();
    end
endmodule : input_level_detector_tb_top
